// File: src/ssbs_consts.svh
`ifndef SSBS_CONSTS_SVH
`define SSBS_CONSTS_SVH

`define SSBS_ADDR_ZERO_SPD      16'h014C
`define SSBS_ADDR_TARGET_SPD    16'h014E
`define SSBS_ADDR_ANA_SPD_FS    16'h0150
`define SSBS_ADDR_ANA_TRQ_FS    16'h0152
`define SSBS_ADDR_BRK_ON_DLY    16'h0154
`define SSBS_ADDR_BRK_OFF_DLY   16'h0156
`define SSBS_ADDR_GEAR_NUM1     16'h0158
`define SSBS_ADDR_STATUS        16'h01FE

`define SSBS_RST_ZERO_SPD       16'h0064
`define SSBS_RST_TARGET_SPD     16'h0BB8
`define SSBS_RST_ANA_SPD_FS     16'h0BB8
`define SSBS_RST_ANA_TRQ_FS     16'h0064
`define SSBS_RST_BRK_ON_DLY     16'h0000
`define SSBS_RST_BRK_OFF_DLY    16'h0000
`define SSBS_RST_GEAR_NUM1      32'h0000_0010

`define SSBS_MAX_ZERO_SPD       16'h07D0
`define SSBS_MAX_TARGET_SPD     16'h1388
`define SSBS_MAX_ANA_SPD_FS     16'h2710
`define SSBS_MAX_ANA_TRQ_FS     16'h03E8
`define SSBS_MAX_BRK_DLY        16'h03E8
`define SSBS_MIN_BRK_OFF_DLY    -16'sh03E8
`define SSBS_MAX_GEAR_NUM1      32'h03FF_FFFF
`define SSBS_MIN_GEAR_NUM1      32'h0000_0001

`define SSBS_STAT_ZERO_BIT      0
`define SSBS_STAT_TARGET_BIT    1
`define SSBS_STAT_BRAKE_BIT     2
`define SSBS_STAT_POWER_BIT     3

`define SSBS_SPD_SCALE          18'h0000A
`define SSBS_ANA_FULL_MV        34'sh0_0000_2710
`define SSBS_CLK_PERIOD_NS      25
`define SSBS_MS_NS              1000000
`define SSBS_EXCL_FAULT         8'h16

`endif

// File: src/ssbs_pkg.sv
package ssbs_pkg;

    typedef enum logic [1:0] {
        SSBS_MODE_POS,
        SSBS_MODE_SPEED,
        SSBS_MODE_TORQUE
    } ssbs_mode_t;

    typedef struct packed {
        logic        wrEn;
        logic        rdEn;
        logic [15:0] addr;
        logic [31:0] data;
    } ssbs_param_req_t;

    typedef struct packed {
        logic        servoOnCmd;
        logic        faultActive;
        logic [7:0]  faultCode;
    } ssbs_stop_t;

endpackage

// File: src/ssbs_speed_brake_seq.sv
`timescale 1ns/100ps
`include "ssbs_consts.svh"
// What this block does
// R1 - zero-speed flag when speed at/below threshold
// R2 - zero-speed holds until speed exceeds threshold
// R3 - target flag when either-direction speed reaches setting
// R4 - target flag drops when speed below setting
// R5 - analog speed: volts times full scale / 10
// R6 - analog torque: volts times full scale / 10
// R7 - brake release waits on-delay after servo on
// R8 - brake engages after signed off-delay after off
// R9 - zero speed during off-wait engages brake early
// R10 - off-delay expiry engages brake regardless of speed
// R11 - forced stops treat negative off-delay as zero
// R12 - hold first gear numerator, 1 to 2^26-1
// R13 - compare absolute filtered speed, both directions
module ssbs_speed_brake_seq #(
    parameter int SPD_W           = 18,
    parameter int CYCLES_PER_MS   = `SSBS_MS_NS / `SSBS_CLK_PERIOD_NS,
    parameter logic [7:0] EXCL_FAULT_CODE = `SSBS_EXCL_FAULT
) (
    input  wire logic                     sys_clk,
    input  wire logic                     resetn,
    input  wire ssbs_pkg::ssbs_param_req_t paramReq,
    output      logic [31:0]              paramRdData_r,
    output      logic                     paramRdValid_r,
    output      logic                     paramWrErr_r,
    input  wire logic signed [SPD_W-1:0]  motorSpeed,
    input  wire ssbs_pkg::ssbs_mode_t     ctrlMode,
    input  wire logic signed [15:0]       analogSpeedMv,
    input  wire logic signed [15:0]       analogTorqueMv,
    input  wire ssbs_pkg::ssbs_stop_t     stopIn,
    input  wire logic                     emergencyStopInput,
    output      logic                     zeroSpeedFlag_r,
    output      logic                     targetSpeedReachedFlag_r,
    output      logic                     brakeReleaseOutput_r,
    output      logic                     servoPower_r,
    output      logic signed [15:0]       speedCommand_r,
    output      logic signed [15:0]       speedLimit_r,
    output      logic signed [15:0]       torqueCommand_r,
    output      logic signed [15:0]       torqueLimit_r,
    output      logic [31:0]              gearNumeratorFirst_r
);
    import ssbs_pkg::*;

    typedef enum logic [2:0] {BRK_HELD, BRK_ON_WAIT, BRK_RELEASED, BRK_OFF_WAIT, BRK_PRE_ENGAGE} ssbs_brk_t;

    function automatic logic signed [15:0] scaleAnalog(input logic signed [15:0] mv, input logic [15:0] fs);
        logic signed [33:0] prod;
        prod = 34'(mv) * $signed({18'h00000, fs});
        return 16'(prod / `SSBS_ANA_FULL_MV);
    endfunction

    logic [15:0] zeroSpdThr_r, targetSpd_r, anaSpdFs_r, anaTrqFs_r, brkOnDly_r, brkOffDly_r;
    logic [15:0] zeroSpdThr_nxt, targetSpd_nxt, anaSpdFs_nxt, anaTrqFs_nxt, brkOnDly_nxt, brkOffDly_nxt;
    logic [31:0] gearNumeratorFirst_nxt, paramRdData_nxt;
    logic        paramRdValid_nxt, paramWrErr_nxt;
    logic        emgsMeta_r, emgsSync_r;
    logic [SPD_W-1:0] absSpeed;
    logic        zeroSpeed_nxt, targetReached_nxt;
    logic signed [15:0] speedCommand_nxt, speedLimit_nxt, torqueCommand_nxt, torqueLimit_nxt;
    ssbs_brk_t   brkState_r, brkState_nxt;
    logic [10:0] msLeft_r, msLeft_nxt;
    logic [31:0] preCnt_r, preCnt_nxt;
    logic        brakeRelease_nxt, servoPower_nxt, timerDone, forcedStop, driveOn;
    logic signed [15:0] offDelaySigned, effOffDelay;

    // parameter writes, out-of-range or unmapped writes are refused
    always_comb begin
        zeroSpdThr_nxt         = zeroSpdThr_r;
        targetSpd_nxt          = targetSpd_r;
        anaSpdFs_nxt           = anaSpdFs_r;
        anaTrqFs_nxt           = anaTrqFs_r;
        brkOnDly_nxt           = brkOnDly_r;
        brkOffDly_nxt          = brkOffDly_r;
        gearNumeratorFirst_nxt = gearNumeratorFirst_r;
        paramWrErr_nxt         = 1'b0;
        if (paramReq.wrEn) begin
            paramWrErr_nxt = 1'b1;
            case (paramReq.addr)
                `SSBS_ADDR_ZERO_SPD: begin
                    if (paramReq.data <= 32'(`SSBS_MAX_ZERO_SPD)) begin
                        zeroSpdThr_nxt = paramReq.data[15:0];
                        paramWrErr_nxt = 1'b0;
                    end
                end
                `SSBS_ADDR_TARGET_SPD: begin
                    if (paramReq.data <= 32'(`SSBS_MAX_TARGET_SPD)) begin
                        targetSpd_nxt  = paramReq.data[15:0];
                        paramWrErr_nxt = 1'b0;
                    end
                end
                `SSBS_ADDR_ANA_SPD_FS: begin
                    if (paramReq.data <= 32'(`SSBS_MAX_ANA_SPD_FS)) begin
                        anaSpdFs_nxt   = paramReq.data[15:0];
                        paramWrErr_nxt = 1'b0;
                    end
                end
                `SSBS_ADDR_ANA_TRQ_FS: begin
                    if (paramReq.data <= 32'(`SSBS_MAX_ANA_TRQ_FS)) begin
                        anaTrqFs_nxt   = paramReq.data[15:0];
                        paramWrErr_nxt = 1'b0;
                    end
                end
                `SSBS_ADDR_BRK_ON_DLY: begin
                    if (paramReq.data <= 32'(`SSBS_MAX_BRK_DLY)) begin
                        brkOnDly_nxt   = paramReq.data[15:0];
                        paramWrErr_nxt = 1'b0;
                    end
                end
                `SSBS_ADDR_BRK_OFF_DLY: begin
                    if ($signed(paramReq.data[15:0]) >= `SSBS_MIN_BRK_OFF_DLY &&
                        $signed(paramReq.data[15:0]) <= $signed(`SSBS_MAX_BRK_DLY)) begin
                        brkOffDly_nxt  = paramReq.data[15:0];
                        paramWrErr_nxt = 1'b0;
                    end
                end
                `SSBS_ADDR_GEAR_NUM1: begin
                    if (paramReq.data >= `SSBS_MIN_GEAR_NUM1 && paramReq.data <= `SSBS_MAX_GEAR_NUM1) begin
                        gearNumeratorFirst_nxt = paramReq.data; // [R12]
                        paramWrErr_nxt         = 1'b0;
                    end
                end
                default: paramWrErr_nxt = 1'b1;
            endcase
        end
    end

    always_comb begin
        paramRdValid_nxt = paramReq.rdEn;
        paramRdData_nxt  = 32'h0000_0000;
        if (paramReq.rdEn) begin
            case (paramReq.addr)
                `SSBS_ADDR_ZERO_SPD:    paramRdData_nxt = {16'h0000, zeroSpdThr_r};
                `SSBS_ADDR_TARGET_SPD:  paramRdData_nxt = {16'h0000, targetSpd_r};
                `SSBS_ADDR_ANA_SPD_FS:  paramRdData_nxt = {16'h0000, anaSpdFs_r};
                `SSBS_ADDR_ANA_TRQ_FS:  paramRdData_nxt = {16'h0000, anaTrqFs_r};
                `SSBS_ADDR_BRK_ON_DLY:  paramRdData_nxt = {16'h0000, brkOnDly_r};
                `SSBS_ADDR_BRK_OFF_DLY: paramRdData_nxt = {16'h0000, brkOffDly_r};
                `SSBS_ADDR_GEAR_NUM1:   paramRdData_nxt = gearNumeratorFirst_r;
                `SSBS_ADDR_STATUS: begin
                    paramRdData_nxt[`SSBS_STAT_ZERO_BIT]   = zeroSpeedFlag_r;
                    paramRdData_nxt[`SSBS_STAT_TARGET_BIT] = targetSpeedReachedFlag_r;
                    paramRdData_nxt[`SSBS_STAT_BRAKE_BIT]  = brakeReleaseOutput_r;
                    paramRdData_nxt[`SSBS_STAT_POWER_BIT]  = servoPower_r;
                end
                default: paramRdData_nxt = 32'h0000_0000;
            endcase
        end
    end

    // speed flags and analog scaling
    always_comb begin
        absSpeed          = motorSpeed[SPD_W-1] ? SPD_W'(-motorSpeed) : SPD_W'(motorSpeed); // [R13]
        zeroSpeed_nxt     = absSpeed <= SPD_W'(zeroSpdThr_r);                             // [R1] [R2]
        targetReached_nxt = absSpeed >= SPD_W'(SPD_W'(targetSpd_r) * `SSBS_SPD_SCALE);     // [R3] [R4]
        speedCommand_nxt  = 16'sh0000;
        speedLimit_nxt    = 16'sh0000;
        torqueCommand_nxt = 16'sh0000;
        torqueLimit_nxt   = scaleAnalog(analogTorqueMv, anaTrqFs_r);                      // [R6]
        case (ctrlMode)
            SSBS_MODE_SPEED:  speedCommand_nxt = scaleAnalog(analogSpeedMv, anaSpdFs_r);  // [R5]
            SSBS_MODE_TORQUE: begin
                speedLimit_nxt    = scaleAnalog(analogSpeedMv, anaSpdFs_r);               // [R5]
                torqueCommand_nxt = torqueLimit_nxt;                                      // [R6]
                torqueLimit_nxt   = 16'sh0000;
            end
            default: speedCommand_nxt = 16'sh0000;
        endcase
    end

    // brake sequencing
    always_comb begin
        forcedStop     = emgsSync_r || (stopIn.faultActive && stopIn.faultCode != EXCL_FAULT_CODE);
        driveOn        = stopIn.servoOnCmd && !stopIn.faultActive && !emgsSync_r;
        timerDone      = msLeft_r == 11'h000;
        offDelaySigned = $signed(brkOffDly_r);
        effOffDelay    = (forcedStop && offDelaySigned < 16'sh0000) ? 16'sh0000 : offDelaySigned; // [R11]
        brkState_nxt   = brkState_r;
        msLeft_nxt     = msLeft_r;
        preCnt_nxt     = preCnt_r;
        if (!timerDone) begin
            preCnt_nxt = preCnt_r + 32'h0000_0001;
            if (preCnt_r == 32'(CYCLES_PER_MS - 1)) begin
                preCnt_nxt = 32'h0000_0000;
                msLeft_nxt = msLeft_r - 11'h001;
            end
        end
        case (brkState_r)
            BRK_HELD: begin
                if (driveOn) begin
                    brkState_nxt = (brkOnDly_r == 16'h0000) ? BRK_RELEASED : BRK_ON_WAIT; // [R7]
                    msLeft_nxt   = brkOnDly_r[10:0];
                    preCnt_nxt   = 32'h0000_0000;
                end
            end
            BRK_ON_WAIT: begin
                if (!driveOn)
                    brkState_nxt = BRK_HELD;
                else if (timerDone)
                    brkState_nxt = BRK_RELEASED; // [R7]
            end
            BRK_RELEASED: begin
                if (!driveOn) begin
                    preCnt_nxt = 32'h0000_0000;
                    if (effOffDelay > 16'sh0000) begin
                        brkState_nxt = BRK_OFF_WAIT; // [R8]
                        msLeft_nxt   = effOffDelay[10:0];
                    end else if (effOffDelay < 16'sh0000) begin
                        brkState_nxt = BRK_PRE_ENGAGE; // [R8]
                        msLeft_nxt   = 11'(-effOffDelay);
                    end else begin
                        brkState_nxt = BRK_HELD;
                    end
                end
            end
            BRK_OFF_WAIT: begin
                if (zeroSpeedFlag_r || timerDone)
                    brkState_nxt = BRK_HELD; // [R9] [R10]
            end
            BRK_PRE_ENGAGE: begin
                if (forcedStop || timerDone)
                    brkState_nxt = BRK_HELD; // [R11]
            end
            default: brkState_nxt = BRK_HELD;
        endcase
        brakeRelease_nxt = brkState_nxt == BRK_RELEASED || brkState_nxt == BRK_OFF_WAIT;
        servoPower_nxt   = brkState_nxt == BRK_ON_WAIT || brkState_nxt == BRK_RELEASED ||
                           brkState_nxt == BRK_PRE_ENGAGE;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            zeroSpdThr_r             <= `SSBS_RST_ZERO_SPD;
            targetSpd_r              <= `SSBS_RST_TARGET_SPD;
            anaSpdFs_r               <= `SSBS_RST_ANA_SPD_FS;
            anaTrqFs_r               <= `SSBS_RST_ANA_TRQ_FS;
            brkOnDly_r               <= `SSBS_RST_BRK_ON_DLY;
            brkOffDly_r              <= `SSBS_RST_BRK_OFF_DLY;
            gearNumeratorFirst_r     <= `SSBS_RST_GEAR_NUM1;
            paramWrErr_r             <= 1'b0;
            paramRdValid_r           <= 1'b0;
            paramRdData_r            <= 32'h0000_0000;
            emgsMeta_r               <= 1'b0;
            emgsSync_r               <= 1'b0;
            zeroSpeedFlag_r          <= 1'b0;
            targetSpeedReachedFlag_r <= 1'b0;
            speedCommand_r           <= 16'sh0000;
            speedLimit_r             <= 16'sh0000;
            torqueCommand_r          <= 16'sh0000;
            torqueLimit_r            <= 16'sh0000;
            brkState_r               <= BRK_HELD;
            msLeft_r                 <= 11'h000;
            preCnt_r                 <= 32'h0000_0000;
            brakeReleaseOutput_r     <= 1'b0;
            servoPower_r             <= 1'b0;
        end else begin
            zeroSpdThr_r             <= zeroSpdThr_nxt;
            targetSpd_r              <= targetSpd_nxt;
            anaSpdFs_r               <= anaSpdFs_nxt;
            anaTrqFs_r               <= anaTrqFs_nxt;
            brkOnDly_r               <= brkOnDly_nxt;
            brkOffDly_r              <= brkOffDly_nxt;
            gearNumeratorFirst_r     <= gearNumeratorFirst_nxt;
            paramWrErr_r             <= paramWrErr_nxt;
            paramRdValid_r           <= paramRdValid_nxt;
            paramRdData_r            <= paramRdData_nxt;
            emgsMeta_r               <= emergencyStopInput;
            emgsSync_r               <= emgsMeta_r;
            zeroSpeedFlag_r          <= zeroSpeed_nxt;
            targetSpeedReachedFlag_r <= targetReached_nxt;
            speedCommand_r           <= speedCommand_nxt;
            speedLimit_r             <= speedLimit_nxt;
            torqueCommand_r          <= torqueCommand_nxt;
            torqueLimit_r            <= torqueLimit_nxt;
            brkState_r               <= brkState_nxt;
            msLeft_r                 <= msLeft_nxt;
            preCnt_r                 <= preCnt_nxt;
            brakeReleaseOutput_r     <= brakeRelease_nxt;
            servoPower_r             <= servoPower_nxt;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    sequence sCommandedOff;
        brkState_r == BRK_RELEASED && !driveOn && effOffDelay > 16'sh0000;
    endsequence
    sequence sForcedNegOff;
        brkState_r == BRK_RELEASED && !driveOn && forcedStop && offDelaySigned < 16'sh0000;
    endsequence

    a_zero_speed_cmp: assert property (resetn |=> // [R1] [R2]
        zeroSpeedFlag_r == ($past(absSpeed) <= SPD_W'($past(zeroSpdThr_r))))
        else $error("zero-speed flag disagrees with threshold");
    a_target_speed_cmp: assert property (resetn |=> // [R3] [R4]
        targetSpeedReachedFlag_r == ($past(absSpeed) >= SPD_W'(SPD_W'($past(targetSpd_r)) * `SSBS_SPD_SCALE)))
        else $error("target-speed flag disagrees with setting");
    a_target_both_dirs: assert property (motorSpeed == -$past(motorSpeed) && resetn && $past(resetn) // [R13]
        |=> targetSpeedReachedFlag_r == $past(targetSpeedReachedFlag_r))
        else $error("target-speed flag depends on direction");
    a_speed_cmd_scale: assert property (ctrlMode == SSBS_MODE_SPEED |=> // [R5]
        speedCommand_r == scaleAnalog($past(analogSpeedMv), $past(anaSpdFs_r)) && speedLimit_r == 16'sh0000)
        else $error("speed command scaling wrong");
    a_torque_cmd_scale: assert property (ctrlMode == SSBS_MODE_TORQUE |=> // [R6]
        torqueCommand_r == scaleAnalog($past(analogTorqueMv), $past(anaTrqFs_r)) && torqueLimit_r == 16'sh0000)
        else $error("torque command scaling wrong");
    a_on_wait_held: assert property (brkState_r == BRK_ON_WAIT && driveOn && msLeft_r > 11'h001 |=> // [R7]
        !brakeReleaseOutput_r && servoPower_r)
        else $error("brake released before on-delay");
    a_on_zero_delay: assert property (brkState_r == BRK_HELD && driveOn && brkOnDly_r == 16'h0000 |=> // [R7]
        brakeReleaseOutput_r && servoPower_r)
        else $error("brake not released at zero on-delay");
    a_off_wait_entry: assert property (sCommandedOff |=> brakeReleaseOutput_r && !servoPower_r) // [R8]
        else $error("off-delay not started");
    a_off_early_engage: assert property (brkState_r == BRK_OFF_WAIT && zeroSpeedFlag_r |=> // [R9]
        !brakeReleaseOutput_r)
        else $error("brake not engaged at zero speed");
    a_off_expiry: assert property (brkState_r == BRK_OFF_WAIT && timerDone |=> !brakeReleaseOutput_r) // [R10]
        else $error("brake not engaged after off-delay");
    a_forced_neg_zero: assert property (sForcedNegOff |=> !brakeReleaseOutput_r && !servoPower_r) // [R11]
        else $error("negative delay honoured on forced stop");
    a_gear_reject: assert property (paramReq.wrEn && paramReq.addr == `SSBS_ADDR_GEAR_NUM1 && // [R12]
        paramReq.data == 32'h0000_0000 |=> gearNumeratorFirst_r == $past(gearNumeratorFirst_r) && paramWrErr_r)
        else $error("zero gear numerator accepted");
endmodule

// File: tb/ssbs_motor_model.sv
`timescale 1ns/100ps
module ssbs_motor_model (
    input  wire logic               sys_clk,
    input  wire logic               resetn,
    input  wire logic signed [17:0] speedSet,
    input  wire logic signed [17:0] decelStep,
    input  wire logic               servoPower,
    input  wire logic               brakeRelease,
    output      logic signed [17:0] speedFb_r
);
    logic signed [17:0] mag;
    assign mag = (speedFb_r < 0) ? -speedFb_r : speedFb_r;
    // powered: follows set speed; braked and unpowered: at rest; else coasts
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            speedFb_r <= '0;
        end else if (servoPower) begin
            speedFb_r <= speedSet;
        end else if (!brakeRelease || mag <= decelStep) begin
            speedFb_r <= '0;
        end else begin
            speedFb_r <= (speedFb_r < 0) ? speedFb_r + decelStep : speedFb_r - decelStep;
        end
    end
endmodule

// File: tb/speed_status_brake_sequencer_tb.sv
`timescale 1ns/100ps
`include "ssbs_consts.svh"
module speed_status_brake_sequencer_tb;
    import ssbs_pkg::*;
    localparam int CPM = 4;
    logic               sys_clk = 1'b0;
    logic               resetn = 1'b0;
    ssbs_param_req_t    paramReq = '0;
    logic [31:0]        paramRdData_r, gearNumeratorFirst_r;
    logic               paramRdValid_r, paramWrErr_r, zeroSpeedFlag_r, targetSpeedReachedFlag_r;
    logic               brakeReleaseOutput_r, servoPower_r;
    logic signed [17:0] motorSpeed, spdSet = '0, decel = 18'sd1;
    ssbs_mode_t         ctrlMode = SSBS_MODE_POS;
    logic signed [15:0] analogSpeedMv = '0, analogTorqueMv = '0;
    logic signed [15:0] speedCommand_r, speedLimit_r, torqueCommand_r, torqueLimit_r;
    ssbs_stop_t         stopIn = '0;
    logic               emergencyStopInput = 1'b0;
    int                 num_errors = 0, n_checks = 0, cyc = 0, nb, np, thr, tg, s, mv, mt, fs, ft;
    localparam logic [15:0] ADR [7] = '{`SSBS_ADDR_ZERO_SPD, `SSBS_ADDR_TARGET_SPD, `SSBS_ADDR_ANA_SPD_FS,
        `SSBS_ADDR_ANA_TRQ_FS, `SSBS_ADDR_BRK_ON_DLY, `SSBS_ADDR_BRK_OFF_DLY, `SSBS_ADDR_GEAR_NUM1};
    localparam logic [31:0] RST [7] = '{32'h64, 32'hBB8, 32'hBB8, 32'h64, 32'h0, 32'h0, 32'h10};
    localparam logic [31:0] BAD [7] = '{32'h7D1, 32'h1389, 32'h2711, 32'h3E9, 32'h3E9, 32'hFC17, 32'h0400_0000};

    ssbs_speed_brake_seq #(.CYCLES_PER_MS(CPM)) DUT (.sys_clk, .resetn, .paramReq, .paramRdData_r,
        .paramRdValid_r, .paramWrErr_r, .motorSpeed, .ctrlMode, .analogSpeedMv, .analogTorqueMv, .stopIn,
        .emergencyStopInput, .zeroSpeedFlag_r, .targetSpeedReachedFlag_r, .brakeReleaseOutput_r,
        .servoPower_r, .speedCommand_r, .speedLimit_r, .torqueCommand_r, .torqueLimit_r, .gearNumeratorFirst_r);
    ssbs_motor_model motor (.sys_clk, .resetn, .speedSet(spdSet), .decelStep(decel),
        .servoPower(servoPower_r), .brakeRelease(brakeReleaseOutput_r), .speedFb_r(motorSpeed));

    always #12.5 sys_clk = ~sys_clk;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 30000) begin
            num_errors++;
            print_verdict();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chkRange(input string what, input int lo, input int hi, input int seen);
        n_checks++;
        if (seen < lo || seen > hi) begin
            num_errors++;
            $display("unexpected %s: expected %0d..%0d seen %0d", what, lo, hi, seen);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        paramReq <= '{w, !w, a, d};
        @(posedge sys_clk);
        paramReq <= '0;
        @(negedge sys_clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic e);
        acc(1'b1, a, d);
        chk("write refusal", {31'h0, e}, {31'h0, paramWrErr_r});
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        acc(1'b0, a, '0);
        chk("read valid", 32'h1, {31'h0, paramRdValid_r});
        chk("read data", e, paramRdData_r);
    endtask
    // counts edges until brake and power each reach lvl
    task automatic track(input logic lvl, output int b, output int p);
        int n;
        n = 0;
        b = -1;
        p = -1;
        while (n < 3000 && (b < 0 || p < 0)) begin
            @(posedge sys_clk);
            #1;
            n++;
            if (b < 0 && brakeReleaseOutput_r === lvl) b = n;
            if (p < 0 && servoPower_r === lvl) p = n;
        end
    endtask
    function automatic logic [31:0] expFlag(int v, int lim, logic atMost);
        int m;
        m = (v < 0) ? -v : v;
        return atMost ? {31'h0, m <= lim} : {31'h0, m >= lim};
    endfunction
    function automatic logic [31:0] expAna(int v, int f, logic used);
        return used ? {16'h0, 16'(v * f / 10000)} : 32'h0;
    endfunction

    initial begin
        void'($urandom(31325));
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk("gear numerator", 32'h10, gearNumeratorFirst_r);
        for (int i = 0; i < 7; i++) rd(ADR[i], RST[i]);
        rd(16'h0100, 32'h0);
        for (int i = 0; i < 7; i++) wr(ADR[i], BAD[i], 1'b1);
        wr(`SSBS_ADDR_GEAR_NUM1, 32'h0, 1'b1);
        wr(16'h0100, 32'h1, 1'b1);
        for (int i = 0; i < 7; i++) rd(ADR[i], RST[i]);
        wr(`SSBS_ADDR_GEAR_NUM1, `SSBS_MAX_GEAR_NUM1, 1'b0);
        chk("gear numerator", `SSBS_MAX_GEAR_NUM1, gearNumeratorFirst_r);
        $display("test registers done");
        @(posedge sys_clk);
        stopIn.servoOnCmd <= 1'b1;
        track(1'b1, nb, np);
        chkRange("power on", 1, 3, np);
        chkRange("release zero delay", 1, 4, nb);
        rd(`SSBS_ADDR_STATUS, 32'h0000_000D);
        for (int i = 0; i < 60; i++) begin
            if (i % 10 == 0) begin
                thr = (i == 0) ? 2000 : $urandom_range(0, 2000);
                tg = (i == 10) ? 0 : $urandom_range(0, 5000);
                wr(`SSBS_ADDR_ZERO_SPD, thr, 1'b0);
                wr(`SSBS_ADDR_TARGET_SPD, tg, 1'b0);
            end
            case (i % 8)
                0: s = thr;
                1: s = thr + 1;
                2: s = -thr;
                3: s = -thr - 1;
                4: s = tg * 10;
                5: s = tg * 10 - 1;
                6: s = -tg * 10;
                default: s = $urandom_range(0, 100000) - 50000;
            endcase
            @(posedge sys_clk);
            spdSet <= 18'(s);
            repeat (3) @(posedge sys_clk);
            #1;
            chk("zero flag", expFlag(s, thr, 1'b1), {31'h0, zeroSpeedFlag_r});
            chk("target flag", expFlag(s, tg * 10, 1'b0), {31'h0, targetSpeedReachedFlag_r});
        end
        $display("test speed flags done");
        for (int i = 0; i < 30; i++) begin
            fs = (i == 0) ? 10000 : $urandom_range(0, 10000);
            ft = (i == 0) ? 1000 : $urandom_range(0, 1000);
            mv = (i == 0) ? 10000 : $urandom_range(0, 20000) - 10000;
            mt = (i == 1) ? -10000 : $urandom_range(0, 20000) - 10000;
            wr(`SSBS_ADDR_ANA_SPD_FS, fs, 1'b0);
            wr(`SSBS_ADDR_ANA_TRQ_FS, ft, 1'b0);
            @(posedge sys_clk);
            ctrlMode <= ssbs_mode_t'(i % 3);
            analogSpeedMv <= 16'(mv);
            analogTorqueMv <= 16'(mt);
            repeat (3) @(posedge sys_clk);
            #1;
            chk("speed command", expAna(mv, fs, i % 3 == 1), {16'h0, speedCommand_r});
            chk("speed limit", expAna(mv, fs, i % 3 == 2), {16'h0, speedLimit_r});
            chk("torque command", expAna(mt, ft, i % 3 == 2), {16'h0, torqueCommand_r});
            chk("torque limit", expAna(mt, ft, i % 3 != 2), {16'h0, torqueLimit_r});
        end
        $display("test analog scaling done");
        @(posedge sys_clk);
        spdSet <= 18'sd20000;
        wr(`SSBS_ADDR_BRK_OFF_DLY, 32'd5, 1'b0);
        @(posedge sys_clk);
        stopIn.servoOnCmd <= 1'b0;
        track(1'b0, nb, np);
        chkRange("power off", 1, 3, np);
        chkRange("brake after delay", 5 * CPM + 1, 5 * CPM + 4, nb);
        wr(`SSBS_ADDR_BRK_ON_DLY, 32'd3, 1'b0);
        wr(`SSBS_ADDR_BRK_OFF_DLY, 32'd200, 1'b0);
        @(posedge sys_clk);
        stopIn.servoOnCmd <= 1'b1;
        track(1'b1, nb, np);
        chkRange("power on", 1, 3, np);
        chkRange("release after delay", 3 * CPM + 1, 3 * CPM + 4, nb);
        repeat (3) @(posedge sys_clk);
        decel <= 18'sd2000;
        stopIn.servoOnCmd <= 1'b0;
        track(1'b0, nb, np);
        chkRange("brake at zero speed", 8, 18, nb);
        $display("test brake timing done");
        wr(`SSBS_ADDR_BRK_ON_DLY, 32'd0, 1'b0);
        wr(`SSBS_ADDR_BRK_OFF_DLY, 32'h0000_FFFD, 1'b0);
        for (int k = 0; k < 4; k++) begin
            @(posedge sys_clk);
            stopIn <= '{1'b1, 1'b0, 8'h00};
            track(1'b1, nb, np);
            @(posedge sys_clk);
            if (k == 0) stopIn.servoOnCmd <= 1'b0;
            if (k == 1) emergencyStopInput <= 1'b1;
            if (k == 2) stopIn <= '{1'b1, 1'b1, 8'h01};
            if (k == 3) stopIn <= '{1'b1, 1'b1, `SSBS_EXCL_FAULT};
            track(1'b0, nb, np);
            chkRange("brake engage", 1, 5, nb);
            chkRange("power hold", (k == 1 || k == 2) ? 1 : 3 * CPM + 1,
                     (k == 1 || k == 2) ? 5 : 3 * CPM + 5, np);
            @(posedge sys_clk);
            stopIn <= '0;
            emergencyStopInput <= 1'b0;
            repeat (6) @(posedge sys_clk);
        end
        $display("test negative off delay done");
        print_verdict();
    end
endmodule
